// File: src/efic_defines.svh
`ifndef EFIC_DEFINES_SVH
`define EFIC_DEFINES_SVH
`define EFIC_OP_WIPE        8'h24
`define EFIC_OP_UNMASK      8'h19
`define EFIC_OP_MASK_OFF    8'h1a
`define EFIC_OP_VECTOR      8'h25
`define EFIC_OP_EXIT        8'h26
`define EFIC_IRQ_GLOBAL     8'hff
`define EFIC_ST_OK          8'h64
`define EFIC_ST_BAD_SUM     8'h01
`define EFIC_ST_BAD_OP      8'h02
`define EFIC_FRAME_LEN      4'h9
`define EFIC_NUM_IRQ        32
`define EFIC_NUM_FLAG       5
`define EFIC_WIPE_ALL       8'h00
`define EFIC_FLAG_TIMEOUT   0
`define EFIC_FLAG_ALARM     1
`define EFIC_FLAG_DEVIATION 2
`define EFIC_FLAG_POSITION  3
`define EFIC_FLAG_SHUTDOWN  4
`define EFIC_REG_STATUS     4'h0
`define EFIC_REG_MASK       4'h1
`define EFIC_REG_FLAGS      4'h2
`define EFIC_REG_ENABLE     4'h3
`define EFIC_REG_GLOBAL     4'h4
`define EFIC_EV_BAD_FRAME   0
`define EFIC_EV_ENTRY       1
`define EFIC_EV_EXIT        2
`endif

// File: src/efic_pkg.sv
package efic_pkg;
    typedef logic [7:0]  efic_byte_t;
    typedef logic [31:0] efic_word_t;
    typedef struct packed {
        efic_word_t accu;
        efic_word_t xreg;
        efic_byte_t flags;
        efic_word_t pc;
    } efic_ctx_t;
    typedef struct packed {
        efic_byte_t addr;
        efic_byte_t op;
        efic_byte_t typ;
        efic_byte_t bank;
        efic_word_t value;
    } efic_cmd_t;
    typedef enum logic [1:0] {
        EFIC_ST_RUN = 2'b00,
        EFIC_ST_IN_HANDLER = 2'b01
    } efic_state_t;
    function automatic efic_byte_t efic_add8(input efic_byte_t a, input efic_byte_t b);
        return efic_byte_t'(a + b);
    endfunction
endpackage

// File: src/efic_cmd_if.sv
`timescale 1ns/100ps
`default_nettype none
interface efic_cmd_if;
    import efic_pkg::*;
    logic      valid;
    logic      sum_ok;
    efic_cmd_t cmd;
    modport src (output valid, output sum_ok, output cmd);
    modport dst (input valid, input sum_ok, input cmd);
endinterface
`default_nettype wire

// File: src/efic_frame_rx.sv
`timescale 1ns/100ps
`default_nettype none
`include "efic_defines.svh"
module efic_frame_rx
    import efic_pkg::*;
(
    input  wire logic       ref_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       byte_valid_in,
    input  wire efic_byte_t byte_in,
    efic_cmd_if.src         cmd_out
);
    typedef struct packed {
        logic [3:0] cnt;
        efic_byte_t sum;
        logic [63:0] buf_b;
        logic       valid;
        logic       ok;
    } efic_rx_t;
    efic_rx_t q, d;
    always_comb begin
        d = q;
        d.valid = 1'b0;
        if (byte_valid_in) begin
            if (q.cnt == `EFIC_FRAME_LEN - 4'h1) begin
                d.ok    = (q.sum == byte_in);
                d.valid = 1'b1;
                d.cnt   = 4'h0;
                d.sum   = 8'h00;
            end else begin
                d.buf_b = {q.buf_b[55:0], byte_in};
                d.sum   = efic_add8(q.sum, byte_in);
                d.cnt   = q.cnt + 4'h1;
            end
        end
    end
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
    assign cmd_out.valid  = q.valid;
    assign cmd_out.sum_ok = q.ok;
    assign cmd_out.cmd    = q.buf_b;
    chk_frame_after_nine: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in)
        byte_valid_in && q.cnt == 4'h8 |=> cmd_out.valid && q.cnt == 4'h0)
        else $error("frame end not flagged");
endmodule // efic_frame_rx
`default_nettype wire

// File: src/efic_ctx_store.sv
`timescale 1ns/100ps
`default_nettype none
`include "efic_defines.svh"
module efic_ctx_store
    import efic_pkg::*;
(
    input  wire logic      ref_clk_in,
    input  wire logic      rst_n_in,
    input  wire logic      save_in,
    input  wire efic_ctx_t ctx_in,
    output efic_ctx_t      ctx_out
);
    typedef struct packed {
        efic_ctx_t saved;
    } efic_cs_t;
    efic_cs_t q, d;
    always_comb begin
        d = q;
        if (save_in) begin
            d.saved = ctx_in;
        end
    end
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
    assign ctx_out = q.saved;
    chk_save_holds_ctx: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in)
        save_in |=> ctx_out == $past(ctx_in))
        else $error("context not saved");
endmodule // efic_ctx_store
`default_nettype wire

// File: src/efic_top.sv
// Behaviour
// - code 36 wipes selected error flags
// - type 0 all, 1..5 single flag
// - code 25 sets one source enable
// - number 255 sets global enable
// - code 26 clears one source enable
// - number 255 clears global enable
// - code 37 stores handler entry vector
// - redefinition overwrites stored vector
// - code 38 restores saved context, resumes
// - direct mode replies status 100 to good frames with known codes
// - frame: addr, op, type, bank, value, sum
`timescale 1ns/100ps
`default_nettype none
`include "efic_defines.svh"
module efic_top
    import efic_pkg::*;
(
    input  wire logic                      ref_clk_in,
    input  wire logic                      rst_n_in,
    input  wire logic                      byte_valid_in,
    input  wire efic_byte_t                byte_in,
    input  wire logic                      direct_mode_in,
    input  wire logic                      prog_cmd_valid_in,
    input  wire efic_cmd_t                 prog_cmd_in,
    input  wire logic [`EFIC_NUM_IRQ-1:0]  irq_src_in,
    input  wire logic [`EFIC_NUM_FLAG-1:0] err_set_in,
    input  wire efic_ctx_t                 cur_ctx_in,
    input  wire logic [3:0]                reg_addr_in,
    input  wire efic_word_t                reg_wdata_in,
    input  wire logic                      reg_wr_in,
    input  wire logic                      reg_rd_in,
    output efic_word_t                     reg_rdata_out,
    output logic                           irq_out,
    output logic                           reply_valid_out,
    output efic_byte_t                     reply_status_out,
    output efic_byte_t                     reply_op_out,
    output logic [`EFIC_NUM_FLAG-1:0]      err_flags_out,
    output logic                           jump_out,
    output efic_word_t                     jump_pc_out,
    output logic                           restore_out,
    output efic_ctx_t                      restore_ctx_out,
    output logic                           in_handler_out
);
    typedef struct packed {
        efic_state_t                 st;
        logic [`EFIC_NUM_FLAG-1:0]   flags;
        logic [`EFIC_NUM_IRQ-1:0]    en;
        logic                        gen;
        logic [2:0]                  ev;
        logic [2:0]                  mask;
        logic                        rep_v;
        efic_byte_t                  rep_st;
        efic_byte_t                  rep_op;
        logic                        jmp;
        efic_word_t                  jpc;
        logic                        rst_o;
        efic_word_t                  rdata;
    } efic_st_t;

    efic_st_t q, d;
    efic_word_t vec_q [`EFIC_NUM_IRQ];
    efic_cmd_if cmd_bus ();
    efic_ctx_t  saved_ctx;
    logic       save_now;
    logic       cmd_go;
    efic_cmd_t  cmd;
    logic       pend_any;
    logic [4:0] pend_idx;
    logic       vec_we;

    efic_frame_rx u_rx (
        .ref_clk_in    (ref_clk_in),
        .rst_n_in      (rst_n_in),
        .byte_valid_in (byte_valid_in),
        .byte_in       (byte_in),
        .cmd_out       (cmd_bus.src)
    );

    efic_ctx_store u_ctx (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .save_in    (save_now),
        .ctx_in     (cur_ctx_in),
        .ctx_out    (saved_ctx)
    );

    function automatic logic [4:0] efic_first(input logic [`EFIC_NUM_IRQ-1:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = `EFIC_NUM_IRQ - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    // host frames only count in direct mode; program commands otherwise
    assign cmd_go = direct_mode_in ? (cmd_bus.valid && cmd_bus.sum_ok)
                                   : prog_cmd_valid_in;
    assign cmd    = direct_mode_in ? cmd_bus.cmd : prog_cmd_in;
    assign vec_we = cmd_go && cmd.op == `EFIC_OP_VECTOR && cmd.typ < 8'(`EFIC_NUM_IRQ);
    assign pend_any = q.gen && |(irq_src_in & q.en) && q.st == EFIC_ST_RUN && !cmd_go;
    assign pend_idx = efic_first(irq_src_in & q.en);
    assign save_now = pend_any;

    always_comb begin
        d = q;
        d.rep_v = 1'b0;
        d.jmp   = 1'b0;
        d.rst_o = 1'b0;
        d.rdata = '0;
        // hardware fault events set, wipe below clears; set applied last wins
        if (cmd_go) begin
            unique case (cmd.op)
                `EFIC_OP_WIPE: begin
                    if (cmd.typ == `EFIC_WIPE_ALL) begin
                        d.flags = '0;
                    end else if (cmd.typ <= 8'(`EFIC_NUM_FLAG)) begin
                        d.flags[cmd.typ[2:0] - 3'h1] = 1'b0;
                    end
                end
                `EFIC_OP_UNMASK: begin
                    if (cmd.typ == `EFIC_IRQ_GLOBAL) begin
                        d.gen = 1'b1;
                    end else if (cmd.typ < 8'(`EFIC_NUM_IRQ)) begin
                        d.en[cmd.typ[4:0]] = 1'b1;
                    end
                end
                `EFIC_OP_MASK_OFF: begin
                    if (cmd.typ == `EFIC_IRQ_GLOBAL) begin
                        d.gen = 1'b0;
                    end else if (cmd.typ < 8'(`EFIC_NUM_IRQ)) begin
                        d.en[cmd.typ[4:0]] = 1'b0;
                    end
                end
                `EFIC_OP_VECTOR: begin
                end
                `EFIC_OP_EXIT: begin
                    // exit only meaningful inside a handler
                    if (q.st == EFIC_ST_IN_HANDLER) begin
                        d.rst_o = 1'b1;
                        d.st    = EFIC_ST_RUN;
                        d.ev[`EFIC_EV_EXIT] = 1'b1;
                    end
                end
                default: begin
                end
            endcase
            if (direct_mode_in) begin
                d.rep_v  = 1'b1;
                d.rep_op = cmd.op;
                d.rep_st = (cmd.op == `EFIC_OP_WIPE || cmd.op == `EFIC_OP_UNMASK ||
                            cmd.op == `EFIC_OP_MASK_OFF || cmd.op == `EFIC_OP_VECTOR ||
                            cmd.op == `EFIC_OP_EXIT) ? `EFIC_ST_OK : `EFIC_ST_BAD_OP;
            end
        end else if (direct_mode_in && cmd_bus.valid) begin
            d.rep_v  = 1'b1;
            d.rep_op = cmd_bus.cmd.op;
            d.rep_st = `EFIC_ST_BAD_SUM;
            d.ev[`EFIC_EV_BAD_FRAME] = 1'b1;
        end
        if (pend_any) begin
            d.jmp = 1'b1;
            d.jpc = vec_q[pend_idx];
            d.st  = EFIC_ST_IN_HANDLER;
            d.ev[`EFIC_EV_ENTRY] = 1'b1;
        end
        d.flags = d.flags | err_set_in;
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                `EFIC_REG_STATUS: d.ev   = d.ev & ~reg_wdata_in[2:0] | (d.ev & ~q.ev);
                `EFIC_REG_MASK:   d.mask = reg_wdata_in[2:0];
                `EFIC_REG_ENABLE: d.en   = reg_wdata_in;
                `EFIC_REG_GLOBAL: d.gen  = reg_wdata_in[0];
                default: begin
                end
            endcase
        end
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                `EFIC_REG_STATUS: d.rdata = {29'h0, q.ev};
                `EFIC_REG_MASK:   d.rdata = {29'h0, q.mask};
                `EFIC_REG_FLAGS:  d.rdata = {27'h0, q.flags};
                `EFIC_REG_ENABLE: d.rdata = q.en;
                `EFIC_REG_GLOBAL: d.rdata = {31'h0, q.gen};
                default:          d.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // vectors kept out of the reset struct; unset entries read zero
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < `EFIC_NUM_IRQ; i++) begin
                vec_q[i] <= 32'h0;
            end
        end else if (vec_we) begin
            vec_q[cmd.typ[4:0]] <= cmd.value;
        end
    end

    assign reg_rdata_out    = q.rdata;
    assign irq_out          = |(q.ev & q.mask);
    assign reply_valid_out  = q.rep_v;
    assign reply_status_out = q.rep_st;
    assign reply_op_out     = q.rep_op;
    assign err_flags_out    = q.flags;
    assign jump_out         = q.jmp;
    assign jump_pc_out      = q.jpc;
    assign restore_out      = q.rst_o;
    assign restore_ctx_out  = saved_ctx;
    assign in_handler_out   = q.st == EFIC_ST_IN_HANDLER;

    chk_wipe_all_clears: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in)
        cmd_go && cmd.op == `EFIC_OP_WIPE && cmd.typ == 8'h00 && err_set_in == '0
        |=> err_flags_out == '0) else $error("wipe all failed");
    chk_wipe_timeout: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in)
        cmd_go && cmd.op == `EFIC_OP_WIPE && cmd.typ == 8'h01 && !err_set_in[0]
        |=> !err_flags_out[0]) else $error("timeout wipe failed");
    chk_global_on: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in)
        cmd_go && cmd.op == `EFIC_OP_UNMASK && cmd.typ == 8'hff && !reg_wr_in
        |=> q.gen) else $error("global enable not set");
    chk_global_off: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in)
        !q.gen |=> !jump_out) else $error("entry while global off");
    chk_src_disabled: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in)
        cmd_go && cmd.op == `EFIC_OP_MASK_OFF && cmd.typ == 8'h00 && !reg_wr_in
        |=> !q.en[0]) else $error("source not disabled");
    chk_vector_store: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in)
        vec_we |=> vec_q[$past(cmd.typ[4:0])] == $past(cmd.value))
        else $error("vector not stored");
    chk_exit_restore: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in)
        cmd_go && cmd.op == `EFIC_OP_EXIT && in_handler_out
        |=> restore_out && !in_handler_out) else $error("exit did not restore");
    chk_reply_ok: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in)
        direct_mode_in && cmd_go && cmd.op == `EFIC_OP_VECTOR
        |=> reply_valid_out && reply_status_out == 8'h64) else $error("bad reply");
    chk_entry_jump: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in)
        pend_any |=> jump_out && in_handler_out) else $error("no jump on entry");
    chk_wipe_shutdown: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in)
        cmd_go && cmd.op == `EFIC_OP_WIPE && cmd.typ == 8'h05 && !err_set_in[4]
        |=> !err_flags_out[4]) else $error("shutdown wipe failed");
    chk_src_enable: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in)
        cmd_go && cmd.op == `EFIC_OP_UNMASK && cmd.typ < 8'h20 && !reg_wr_in
        |=> q.en[$past(cmd.typ[4:0])]) else $error("source not enabled");
    chk_global_clear: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in)
        cmd_go && cmd.op == `EFIC_OP_MASK_OFF && cmd.typ == 8'hff && !reg_wr_in
        |=> !q.gen) else $error("global enable not cleared");
    chk_jump_vector: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in)
        pend_any |=> jump_pc_out == $past(vec_q[pend_idx])) else $error("wrong handler entry");
    chk_stray_exit: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in)
        cmd_go && cmd.op == `EFIC_OP_EXIT && !in_handler_out |=> !restore_out)
        else $error("restore outside handler");
    chk_wipe_reply: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in)
        direct_mode_in && cmd_go && cmd.op == `EFIC_OP_WIPE
        |=> reply_valid_out && reply_status_out == 8'h64) else $error("no ok reply to wipe");
    chk_prog_no_reply: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in)
        !direct_mode_in |=> !reply_valid_out) else $error("reply in program mode");
    chk_bad_sum_reply: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in)
        direct_mode_in && cmd_bus.valid && !cmd_bus.sum_ok
        |=> reply_valid_out && reply_status_out == 8'h01) else $error("bad sum not refused");
endmodule // efic_top
`default_nettype wire

// File: dv/efic_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module efic_host_model
    import efic_pkg::*;
(
    input  wire logic      clk_in,
    output var logic       byte_valid_out,
    output var efic_byte_t byte_out
);
    initial begin
        byte_valid_out = 1'b0;
        byte_out       = 8'h00;
    end
    // idle or stalled link shows the inverse byte, so a stale copy never looks valid
    task automatic send(input efic_cmd_t c, input logic bad);
        efic_byte_t f [9];
        efic_byte_t s;
        s = 8'h00;
        for (int i = 0; i < 8; i++) begin
            f[i] = c[63-8*i -: 8];
        end
        for (int i = 0; i < 8; i++) begin
            s = s + f[i];
        end
        f[8] = bad ? ~s : s;
        for (int i = 0; i < 9; i++) begin
            @(posedge clk_in);
            byte_valid_out <= 1'b1;
            byte_out       <= f[i];
            if ($urandom_range(3) == 0) begin
                @(posedge clk_in);
                byte_valid_out <= 1'b0;
                byte_out       <= ~f[i];
            end
        end
        @(posedge clk_in);
        byte_valid_out <= 1'b0;
        byte_out       <= ~f[8];
    endtask
endmodule // efic_host_model
`default_nettype wire

// File: dv/efic_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module efic_top_tb;
    import efic_pkg::*;
    logic        clk, rst_n, dm, pv, wr, rd, bv, irq, rv, jo, ro, ih;
    efic_byte_t  bt, rs, rop, rstat, rops;
    efic_cmd_t   pc;
    logic [31:0] src;
    logic [4:0]  es, ef, ex;
    logic [3:0]  ra;
    efic_ctx_t   ctx, svc, rc, rctx;
    efic_word_t  wd, rdata, jp, jpc, v1, v2;
    int          miscompares, total_checks, nrep, njump, nrest, n0, k;

    efic_top efic_top_i (.ref_clk_in(clk), .rst_n_in(rst_n), .byte_valid_in(bv),
        .byte_in(bt), .direct_mode_in(dm), .prog_cmd_valid_in(pv), .prog_cmd_in(pc),
        .irq_src_in(src), .err_set_in(es), .cur_ctx_in(ctx), .reg_addr_in(ra),
        .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .irq_out(irq), .reply_valid_out(rv), .reply_status_out(rs),
        .reply_op_out(rop), .err_flags_out(ef), .jump_out(jo), .jump_pc_out(jp),
        .restore_out(ro), .restore_ctx_out(rc), .in_handler_out(ih));
    efic_host_model efic_host_model_i (.clk_in(clk), .byte_valid_out(bv), .byte_out(bt));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // pulses are caught mid-cycle, where the registered outputs have settled
    always @(negedge clk) begin
        if (rv === 1'b1) begin
            nrep++;
            rstat = rs;
            rops  = rop;
        end
        if (jo === 1'b1) begin
            njump++;
            jpc = jp;
        end
        if (ro === 1'b1) begin
            nrest++;
            rctx = rc;
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string n, input logic [103:0] e, input logic [103:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wait_cnt(ref int c, input int n);
        for (int i = 0; i < 60 && c == n; i++) @(posedge clk);
        if (c == n) begin
            miscompares++;
            $display("BAD wait expected event seen none");
            give_verdict();
        end
    endtask

    // random choice between host frame and stored-program path
    task automatic do_cmd(input efic_byte_t op, input efic_byte_t t, input efic_word_t v);
        efic_cmd_t c;
        int        n;
        c = '{8'h01, op, t, 8'($urandom), v};
        if ($urandom_range(1) == 1) begin
            n = nrep;
            efic_host_model_i.send(c, 1'b0);
            wait_cnt(nrep, n);
            chk("status", 8'h64, rstat);
            chk("reply op", op, rops);
        end else begin
            @(posedge clk);
            dm <= 1'b0;
            pv <= 1'b1;
            pc <= c;
            @(posedge clk);
            pv <= 1'b0;
            dm <= 1'b1;
            @(posedge clk);
        end
        #1;
    endtask

    task automatic wreg(input logic [3:0] a, input efic_word_t d);
        @(posedge clk);
        ra <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rchk(input string n, input logic [3:0] a, input efic_word_t e);
        @(posedge clk);
        ra <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(n, e, rdata);
    endtask

    task automatic pulse_err();
        @(posedge clk);
        es <= 5'h1f;
        @(posedge clk);
        es <= 5'h00;
    endtask

    task automatic settle();
        @(posedge clk);
        #1;
    endtask

    initial begin
        {rst_n, pv, wr, rd, es, src, ra, wd, pc} = '0;
        dm = 1'b1;
        ctx = '0;
        void'($urandom(80003));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        settle();
        chk("flags", 5'h00, ef);
        chk("irq", 1'b0, irq);
        for (int t = 0; t <= 6; t++) begin
            pulse_err();
            do_cmd(8'h24, 8'(t), $urandom);
            ex = (t == 0) ? 5'h00 : (t > 5) ? 5'h1f : 5'h1f & ~(5'h01 << (t - 1));
            chk("flags", ex, ef);
        end
        rchk("flag reg", 4'h2, 32'h1f);
        n0 = nrep;
        efic_host_model_i.send('{8'h01, 8'h24, 8'h00, 8'h00, 32'h0}, 1'b1);
        wait_cnt(nrep, n0);
        chk("sum status", 8'h01, rstat);
        chk("flags", 5'h1f, ef);
        rchk("status", 4'h0, 32'h1);
        n0 = nrep;
        efic_host_model_i.send('{8'h01, 8'h07, 8'h00, 8'h00, 32'h0}, 1'b0);
        wait_cnt(nrep, n0);
        chk("op status", 8'h02, rstat);
        chk("op echo", 8'h07, rops);
        wreg(4'h0, 32'h7);
        k = $urandom_range(31);
        v1 = $urandom;
        v2 = ~v1;
        do_cmd(8'h25, 8'(k), v1);
        do_cmd(8'h25, 8'(k), v2);
        do_cmd(8'h19, 8'(k), $urandom);
        do_cmd(8'h19, 8'hff, $urandom);
        rchk("enables", 4'h3, 32'h1 << k);
        rchk("global", 4'h4, 32'h1);
        wreg(4'h1, 32'h7);
        rchk("mask", 4'h1, 32'h7);
        svc = {$urandom, $urandom, 8'($urandom), $urandom};
        ctx <= svc;
        n0 = njump;
        src <= 32'h1 << k;
        wait_cnt(njump, n0);
        src <= '0;
        chk("vector", v2, jpc);
        settle();
        ctx <= ~svc;
        chk("in handler", 1'b1, ih);
        chk("irq", 1'b1, irq);
        rchk("status", 4'h0, 32'h2);
        wreg(4'h0, 32'h2);
        settle();
        chk("irq", 1'b0, irq);
        n0 = nrest;
        do_cmd(8'h26, 8'hff, 32'h0);
        wait_cnt(nrest, n0);
        chk("context", svc, rctx);
        settle();
        chk("in handler", 1'b0, ih);
        chk("irq", 1'b1, irq);
        wreg(4'h1, 32'h0);
        settle();
        chk("masked irq", 1'b0, irq);
        wreg(4'h0, 32'h7);
        n0 = nrest;
        do_cmd(8'h26, 8'hff, 32'h0);
        repeat (4) @(posedge clk);
        chk("stray exit", n0, nrest);
        do_cmd(8'h1a, 8'(k), $urandom);
        rchk("enables", 4'h3, 32'h0);
        do_cmd(8'h1a, 8'h00, $urandom);
        n0 = njump;
        src <= 32'h1 << k;
        repeat (20) @(posedge clk);
        chk("jumps", n0, njump);
        do_cmd(8'h1a, 8'hff, $urandom);
        do_cmd(8'h19, 8'(k), $urandom);
        rchk("global", 4'h4, 32'h0);
        repeat (20) @(posedge clk);
        chk("jumps", n0, njump);
        wreg(4'h3, 32'h0);
        wreg(4'h4, 32'h1);
        rchk("global", 4'h4, 32'h1);
        repeat (20) @(posedge clk);
        chk("jumps", n0, njump);
        rchk("unmapped", 4'hc, 32'h0);
        give_verdict();
    end
endmodule // efic_top_tb
`default_nettype wire
